// *** design/iis_status.sv ***
// masked interrupt status, raw status and mask registers of the two-wire controller
// assumes event strobes and fifo levels come from logic on clk_sys; scl and sda come from pins
`default_nettype none

module iis_sticky #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_d,
  output logic      flag_q
);

  // set wins over a clear in the same cycle
  assign flag_d = set_i | (flag_q & ~clr_i);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_q <= RST_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : iis_sticky

module iis_status (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  // register port
  input  wire logic [31:0]                  reg_addr,
  input  wire logic                         reg_rd,
  input  wire logic                         reg_wr,
  input  wire logic [iis_pkg::REG_W-1:0]    reg_wdata,
  output logic      [iis_pkg::REG_W-1:0]    reg_rdata_q,
  // bus pins
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output logic                              scl_o_q,
  output logic                              scl_oe_q,
  // controls
  input  wire logic                         enable_bit,
  input  wire logic                         internal_enable,
  input  wire logic [iis_pkg::THR_W-1:0]    tx_threshold_field,
  input  wire logic [iis_pkg::THR_W-1:0]    rx_threshold_field,
  // clear register read strobes
  input  wire logic                         general_call_clear_rd,
  input  wire logic                         activity_clear_rd,
  input  wire logic                         combined_clear_rd,
  input  wire logic                         abort_clear_rd,
  input  wire logic                         read_request_clear_rd,
  // data_command_port accesses
  input  wire logic                         data_cmd_wr,
  input  wire logic                         data_cmd_rd,
  // state machine events
  input  wire logic                         fsm_active,
  input  wire logic                         gen_call_acked,
  input  wire logic                         slave_tx_nack,
  input  wire logic                         tx_abort_event,
  input  wire logic [7:0]                   tx_abort_cause,
  input  wire logic                         slave_read_req,
  input  wire logic                         rx_byte_valid,
  input  wire logic [iis_pkg::LVL_W-1:0]    tx_level,
  input  wire logic [iis_pkg::LVL_W-1:0]    rx_level,
  // fifo control
  output logic                              tx_flush_q,
  output logic                              tx_push_q,
  output logic                              rx_flush_q,
  output logic                              rx_push_q,
  output logic      [7:0]                   abort_cause_q
);

  logic [2:0]                scl_sync_q;
  logic [2:0]                sda_sync_q;
  wire  [iis_pkg::NFLAG-1:0] raw_q;
  wire  [iis_pkg::NFLAG-1:0] raw_d;
  logic                      tx_empty_q;
  logic                      rx_full_q;
  logic                      gen_q;
  logic                      gen_d;
  logic                      start_q;
  logic                      start_d;
  logic                      stop_q;
  logic                      stop_d;
  logic                      act_q;
  logic                      act_d;
  logic                      done_q;
  logic                      done_d;
  logic                      abrt_q;
  logic                      abrt_d;
  logic                      rdrq_q;
  logic                      rdrq_d;
  logic                      txov_q;
  logic                      txov_d;
  logic                      rxov_q;
  logic                      rxov_d;
  logic                      rxun_q;
  logic                      rxun_d;
  logic [iis_pkg::NFLAG-1:0] mask_q;
  logic [iis_pkg::NFLAG-1:0] mask_d;
  logic [iis_pkg::REG_W-1:0] rdata_d;

  // bus condition detection on synchronised pins
  wire scl_hi    = scl_sync_q[1] & scl_sync_q[2];
  wire start_det = scl_hi & sda_sync_q[2] & ~sda_sync_q[1];
  wire stop_det  = scl_hi & ~sda_sync_q[2] & sda_sync_q[1];

  wire disabled   = ~enable_bit;
  wire ien_off    = ~internal_enable;
  wire tx_full    = tx_level == iis_pkg::FIFO_DEPTH;
  wire rx_full    = rx_level == iis_pkg::FIFO_DEPTH;
  wire rx_empty   = rx_level == {iis_pkg::LVL_W{1'b0}};

  wire [iis_pkg::THR_W-1:0] tx_lvl_w = {{(iis_pkg::THR_W-iis_pkg::LVL_W){1'b0}}, tx_level};
  wire [iis_pkg::THR_W-1:0] rx_lvl_w = {{(iis_pkg::THR_W-iis_pkg::LVL_W){1'b0}}, rx_level};

  // level flags
  wire tx_empty_lvl = disabled ? fsm_active : (tx_lvl_w <= tx_threshold_field);
  wire rx_full_lvl  = ~disabled & (rx_lvl_w >= rx_threshold_field);

  // set terms
  wire set_gen  = gen_call_acked & enable_bit;
  wire set_act  = fsm_active | start_det | stop_det;
  wire set_acte = set_act & ~disabled;
  wire set_done = slave_tx_nack;
  wire set_abrt = tx_abort_event;
  wire set_rdrq = slave_read_req;
  wire set_txov = data_cmd_wr & tx_full;
  wire set_rxov = rx_byte_valid & rx_full;
  wire set_rxun = data_cmd_rd & rx_empty;

  // clear terms; set wins over clear
  wire clr_gen  = disabled | general_call_clear_rd;
  wire clr_act  = disabled | activity_clear_rd | combined_clear_rd;
  wire clr_abrt = abort_clear_rd;
  wire clr_rdrq = read_request_clear_rd;
  wire clr_err  = ien_off;

  // sticky flag cells
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_GEN_CALL])) i_gen (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_gen),
    .clr_i   (clr_gen),
    .flag_d  (gen_d),
    .flag_q  (gen_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_START])) i_start (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (start_det),
    .clr_i   (combined_clear_rd),
    .flag_d  (start_d),
    .flag_q  (start_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_STOP])) i_stop (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (stop_det),
    .clr_i   (combined_clear_rd),
    .flag_d  (stop_d),
    .flag_q  (stop_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_ACTIVITY])) i_act (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_acte),
    .clr_i   (clr_act),
    .flag_d  (act_d),
    .flag_q  (act_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_TX_DONE])) i_done (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_done),
    .clr_i   (combined_clear_rd),
    .flag_d  (done_d),
    .flag_q  (done_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_TX_ABORT])) i_abrt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_abrt),
    .clr_i   (clr_abrt),
    .flag_d  (abrt_d),
    .flag_q  (abrt_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_RD_REQ])) i_rdrq (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_rdrq),
    .clr_i   (clr_rdrq),
    .flag_d  (rdrq_d),
    .flag_q  (rdrq_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_TX_OVER])) i_txov (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_txov),
    .clr_i   (clr_err),
    .flag_d  (txov_d),
    .flag_q  (txov_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_RX_OVER])) i_rxov (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_rxov),
    .clr_i   (clr_err),
    .flag_d  (rxov_d),
    .flag_q  (rxov_q)
  );
  iis_sticky #(.RST_VAL(iis_pkg::FLAG_RESET[iis_pkg::B_RX_UNDER])) i_rxun (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .set_i   (set_rxun),
    .clr_i   (clr_err),
    .flag_d  (rxun_d),
    .flag_q  (rxun_q)
  );

  // raw status next value
  assign raw_d[iis_pkg::B_GEN_CALL] = gen_d;
  assign raw_d[iis_pkg::B_START]    = start_d;
  assign raw_d[iis_pkg::B_STOP]     = stop_d;
  assign raw_d[iis_pkg::B_ACTIVITY] = act_d;
  assign raw_d[iis_pkg::B_TX_DONE]  = done_d;
  assign raw_d[iis_pkg::B_TX_ABORT] = abrt_d;
  assign raw_d[iis_pkg::B_RD_REQ]   = rdrq_d;
  assign raw_d[iis_pkg::B_TX_EMPTY] = tx_empty_lvl;
  assign raw_d[iis_pkg::B_TX_OVER]  = txov_d;
  assign raw_d[iis_pkg::B_RX_FULL]  = rx_full_lvl;
  assign raw_d[iis_pkg::B_RX_OVER]  = rxov_d;
  assign raw_d[iis_pkg::B_RX_UNDER] = rxun_d;

  // raw status
  assign raw_q[iis_pkg::B_GEN_CALL] = gen_q;
  assign raw_q[iis_pkg::B_START]    = start_q;
  assign raw_q[iis_pkg::B_STOP]     = stop_q;
  assign raw_q[iis_pkg::B_ACTIVITY] = act_q;
  assign raw_q[iis_pkg::B_TX_DONE]  = done_q;
  assign raw_q[iis_pkg::B_TX_ABORT] = abrt_q;
  assign raw_q[iis_pkg::B_RD_REQ]   = rdrq_q;
  assign raw_q[iis_pkg::B_TX_EMPTY] = tx_empty_q;
  assign raw_q[iis_pkg::B_TX_OVER]  = txov_q;
  assign raw_q[iis_pkg::B_RX_FULL]  = rx_full_q;
  assign raw_q[iis_pkg::B_RX_OVER]  = rxov_q;
  assign raw_q[iis_pkg::B_RX_UNDER] = rxun_q;

  // register decode
  wire sel_masked = reg_addr == iis_pkg::OFS_MASKED_STAT;
  wire sel_mask   = reg_addr == iis_pkg::OFS_MASK;
  wire sel_raw    = reg_addr == iis_pkg::OFS_RAW_STAT;

  wire [iis_pkg::NFLAG-1:0] masked = raw_q & mask_q;

  always_comb begin
    mask_d  = mask_q;
    rdata_d = {iis_pkg::REG_W{1'b0}};
    if (reg_wr && sel_mask) begin
      mask_d = reg_wdata[iis_pkg::NFLAG-1:0];
    end
    if (reg_rd && sel_masked) begin
      rdata_d = {4'h0, masked};
    end else if (reg_rd && sel_mask) begin
      rdata_d = {4'h0, mask_q};
    end else if (reg_rd && sel_raw) begin
      rdata_d = {4'h0, raw_q};
    end
  end

  // fifo control: flush tx on abort or disable, rx on disable; keep rx on full
  wire tx_flush_d = raw_d[iis_pkg::B_TX_ABORT] | disabled;
  wire tx_push_d  = data_cmd_wr & ~tx_full & ~tx_flush_d;
  wire rx_push_d  = rx_byte_valid & ~rx_full & enable_bit;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_empty_q <= iis_pkg::FLAG_RESET[iis_pkg::B_TX_EMPTY];
      rx_full_q  <= iis_pkg::FLAG_RESET[iis_pkg::B_RX_FULL];
      mask_q     <= iis_pkg::MASK_RESET;
    end else begin
      tx_empty_q <= tx_empty_lvl;
      rx_full_q  <= rx_full_lvl;
      mask_q     <= mask_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= {iis_pkg::REG_W{1'b0}};
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      abort_cause_q <= 8'h00;
    end else if (set_abrt) begin
      abort_cause_q <= tx_abort_cause;
    end
  end

  // hold scl low while a read request waits for service
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_o_q  <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      scl_o_q  <= 1'b0;
      scl_oe_q <= raw_d[iis_pkg::B_RD_REQ];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_flush_q <= 1'b1;
      tx_push_q  <= 1'b0;
      rx_flush_q <= 1'b1;
      rx_push_q  <= 1'b0;
    end else begin
      tx_flush_q <= tx_flush_d;
      tx_push_q  <= tx_push_d;
      rx_flush_q <= disabled;
      rx_push_q  <= rx_push_d;
    end
  end

endmodule : iis_status

`default_nettype wire

// *** design/iis_pkg.sv ***
// constants for the masked interrupt status logic of the two-wire controller
// assumes a peripheral register port on clk_sys and event strobes from the controller state machines
// Operation
// - general call acked sets bit 11 until cleared
// - general call data goes into receive buffer
// - bit 10 flags start or repeated start
// - bit 9 flags stop condition seen
// - bit 8 latches activity; cleared only by disable, activity clear read or combined clear read
// - bit 7 set on master nack, slave transmit
// - bit 6 set on transmit abort, cause recorded
// - abort flushes transmit fifo until abort clear
// - read request sets bit 5, holds SCL low
// - read request clear read drops bit 5
// - bit 4 while tx level at/below threshold
// - disabled: tx fifo flushed, empty follows activity
// - bit 3 on write to full tx buffer
// - overflow/underflow flags held until internal enable drops
// - bit 2 at/above rx threshold, disable clears
// - bit 1 on byte into full rx buffer
// - bit 0 on data read while empty
// - masked status is raw status and mask
`default_nettype none

package iis_pkg;

  localparam logic [31:0] OFS_MASKED_STAT = 32'h5000132C;
  localparam logic [31:0] OFS_MASK        = 32'h50001330;
  localparam logic [31:0] OFS_RAW_STAT    = 32'h50001334;

  localparam int unsigned REG_W     = 16;
  localparam int unsigned NFLAG     = 12;
  localparam int unsigned LVL_W     = 6;
  localparam int unsigned THR_W     = 8;
  localparam logic [5:0]  FIFO_DEPTH = 6'h20;

  localparam int unsigned B_RX_UNDER = 0;
  localparam int unsigned B_RX_OVER  = 1;
  localparam int unsigned B_RX_FULL  = 2;
  localparam int unsigned B_TX_OVER  = 3;
  localparam int unsigned B_TX_EMPTY = 4;
  localparam int unsigned B_RD_REQ   = 5;
  localparam int unsigned B_TX_ABORT = 6;
  localparam int unsigned B_TX_DONE  = 7;
  localparam int unsigned B_ACTIVITY = 8;
  localparam int unsigned B_STOP     = 9;
  localparam int unsigned B_START    = 10;
  localparam int unsigned B_GEN_CALL = 11;

  localparam logic [11:0] MASK_RESET = 12'h8FF;
  localparam logic [11:0] FLAG_RESET = 12'h000;

endpackage : iis_pkg

`default_nettype wire

// *** tb/iis_remote_master.sv ***
// remote bus master: start, two clocked bits, stop
// assumes scl_in is the resolved clock wire; idle lines pulled high
`default_nettype none
module iis_remote_master (
  input  wire logic go,
  input  wire logic scl_in,
  output var logic  scl_m,
  output var logic  sda_m
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  always @(posedge go) begin
    #30 sda_m = 1'b0;
    #62.5 scl_m = 1'b0;
    #62.5 scl_m = 1'b1;
    wait (scl_in);
    #62.5 scl_m = 1'b0;
    #62.5 scl_m = 1'b1;
    #62.5 sda_m = 1'b1;
  end
endmodule : iis_remote_master
`default_nettype wire

// *** tb/iis_status_properties.sv ***
// port checks of the status block
// assumes it is bound onto iis_status
`default_nettype none
module iis_status_properties (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        scl_o_q,
  input wire logic        scl_oe_q,
  input wire logic        slave_read_req,
  input wire logic        read_request_clear_rd,
  input wire logic        tx_abort_event,
  input wire logic [7:0]  tx_abort_cause,
  input wire logic [7:0]  abort_cause_q,
  input wire logic        tx_flush_q,
  input wire logic        rx_flush_q,
  input wire logic        enable_bit,
  input wire logic        rx_byte_valid,
  input wire logic [5:0]  rx_level,
  input wire logic        rx_push_q,
  input wire logic        data_cmd_wr,
  input wire logic [5:0]  tx_level,
  input wire logic        tx_push_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rr_clear;
    read_request_clear_rd && !slave_read_req;
  endsequence
  sequence s_stretch;
    scl_oe_q && !scl_o_q;
  endsequence
  a_reserved_zero: assert property (reg_rdata_q[15:12] == 4'h0)
    else $error("reserved bits nonzero");
  a_read_idle_zero: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data without read");
  a_read_req_hold: assert property (slave_read_req |=> s_stretch)
    else $error("scl not held low");
  a_read_req_clear: assert property (s_rr_clear |=> !scl_oe_q)
    else $error("scl hold not released");
  a_abort_flush: assert property (tx_abort_event |=> tx_flush_q)
    else $error("tx fifo not flushed");
  a_abort_cause: assert property (tx_abort_event |=> abort_cause_q == $past(tx_abort_cause))
    else $error("abort cause lost");
  a_disable_flush: assert property (!enable_bit |=> tx_flush_q && rx_flush_q)
    else $error("fifos not flushed");
  a_rx_full_drop: assert property (rx_byte_valid && rx_level == iis_pkg::FIFO_DEPTH |=> !rx_push_q)
    else $error("byte pushed into full fifo");
  a_rx_push_take: assert property (rx_byte_valid && rx_level != iis_pkg::FIFO_DEPTH && enable_bit |=> rx_push_q)
    else $error("received byte not pushed");
  a_tx_full_refuse: assert property (data_cmd_wr && tx_level == iis_pkg::FIFO_DEPTH |=> !tx_push_q)
    else $error("write pushed into full tx fifo");
  a_abort_no_push: assert property (tx_abort_event |=> !tx_push_q)
    else $error("tx push during abort");
endmodule : iis_status_properties
bind iis_status iis_status_properties i_props (.clk_sys, .rst_n, .reg_rd, .reg_rdata_q, .scl_o_q, .scl_oe_q,
  .slave_read_req, .read_request_clear_rd, .tx_abort_event, .tx_abort_cause, .abort_cause_q, .tx_flush_q,
  .rx_flush_q, .enable_bit, .rx_byte_valid, .rx_level, .rx_push_q, .data_cmd_wr, .tx_level, .tx_push_q);
`default_nettype wire

// *** tb/iis_status_tb_top.sv ***
// self-checking bench of the status block
// assumes the design, the far-side model and the checker are compiled first
`default_nettype none
module iis_status_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, go = 1'b0;
  logic enable_bit = 1'b0, internal_enable = 1'b0, fsm_active = 1'b0;
  logic [31:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, msk = 16'h08FF;
  logic [11:0] ev = '0, st = '0;
  logic [7:0] tx_threshold_field = 8'h05, rx_threshold_field = 8'h05, tx_abort_cause = '0;
  logic [5:0] tx_level = 6'h0A, rx_level = '0;
  wire logic [15:0] reg_rdata_q;
  wire logic [7:0] abort_cause_q;
  wire logic scl_o_q, scl_oe_q, tx_flush_q, scl_m, sda_m;
  wire logic scl_w = scl_oe_q ? 1'b0 : scl_m;
  int fails = 0, n_checks = 0, cyc = 0, seed = 67;
  int fb[4] = '{11, 7, 6, 5};
  always #5 clk_sys = ~clk_sys;
  iis_remote_master i_far (.go, .scl_in(scl_w), .scl_m, .sda_m);
  iis_status i_dut (.clk_sys, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q, .scl_i(scl_w),
    .sda_i(sda_m), .scl_o_q, .scl_oe_q, .enable_bit, .internal_enable, .tx_threshold_field, .rx_threshold_field,
    .general_call_clear_rd(ev[7]), .activity_clear_rd(ev[8]), .combined_clear_rd(ev[9]),
    .abort_clear_rd(ev[10]), .read_request_clear_rd(ev[11]), .data_cmd_wr(ev[5]), .data_cmd_rd(ev[6]),
    .fsm_active, .gen_call_acked(ev[0]), .slave_tx_nack(ev[1]), .tx_abort_event(ev[2]), .tx_abort_cause,
    .slave_read_req(ev[3]), .rx_byte_valid(ev[4]), .tx_level, .rx_level, .tx_flush_q, .tx_push_q(),
    .rx_flush_q(), .rx_push_q(), .abort_cause_q);
  function automatic logic [15:0] xp();
    logic [15:0] lv;
    lv = enable_bit ? {11'h0, tx_level <= tx_threshold_field, 1'b0, rx_level >= rx_threshold_field, 2'h0}
                    : {11'h0, fsm_active, 4'h0};
    return ({4'h0, st} | lv) & msk;
  endfunction : xp
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(negedge clk_sys) reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys) reg_rd = 1'b0;
    `CK(reg_rdata_q, e)
  endtask : rd
  task automatic chk();
    @(negedge clk_sys);
    rd(iis_pkg::OFS_MASKED_STAT, xp());
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(negedge clk_sys) reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys) reg_wr = 1'b0;
  endtask : wr
  task automatic pl(input int b);
    @(negedge clk_sys) ev[b] = 1'b1;
    @(negedge clk_sys) ev = '0;
  endtask : pl
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    chk();
    rd(iis_pkg::OFS_MASK, 16'h08FF);
    wr(iis_pkg::OFS_MASKED_STAT, 16'hFFFF);
    chk();
    rd(32'h50001000, 16'h0000);
    enable_bit = 1'b1;
    internal_enable = 1'b1;
    msk = 16'h0FFF;
    wr(iis_pkg::OFS_MASK, msk);
    pl(4);
    tx_abort_cause = 8'($random(seed));
    for (int i = 0; i < 4; i++) begin
      pl(i);
      st[fb[i]] = 1'b1;
      chk();
    end
    `CK(abort_cause_q, tx_abort_cause)
    `CK(scl_w, 1'b0)
    `CK(tx_flush_q, 1'b1)
    pl(5);
    pl(11);
    st[5] = 1'b0;
    chk();
    `CK(scl_w, 1'b1)
    pl(10);
    pl(7);
    st[6] = 1'b0;
    st[11] = 1'b0;
    chk();
    `CK(tx_flush_q, 1'b0)
    $display("test events finished");
    fsm_active = 1'b1;
    go = 1'b1;
    repeat (100) @(negedge clk_sys);
    go = 1'b0;
    fsm_active = 1'b0;
    st[10:8] = 3'h7;
    chk();
    pl(8);
    st[8] = 1'b0;
    chk();
    pl(9);
    st = '0;
    chk();
    $display("test bus finished");
    tx_level = 6'h20;
    pl(5);
    rx_level = 6'h20;
    pl(4);
    rx_level = 6'h00;
    pl(6);
    st[3:0] = 4'hB;
    chk();
    enable_bit = 1'b0;
    fsm_active = 1'b1;
    chk();
    internal_enable = 1'b0;
    fsm_active = 1'b0;
    st = '0;
    chk();
    $display("test fifo finished");
    enable_bit = 1'b1;
    internal_enable = 1'b1;
    repeat (20) begin
      tx_level = 6'({$random(seed)} % 33);
      rx_level = 6'({$random(seed)} % 33);
      tx_threshold_field = 8'({$random(seed)} % 34);
      rx_threshold_field = 8'({$random(seed)} % 34);
      msk = 16'($random(seed)) & 16'h0FFF;
      wr(iis_pkg::OFS_MASK, msk);
      chk();
    end
    $display("test random finished");
    report_and_stop();
  end
endmodule : iis_status_tb_top
`default_nettype wire
